// ---- swp_map.vh ----
// Constants of the write-port capture block: register offsets, fields, resets, buffer sizes, responses.
// Included by the design file; holds definitions only.
`ifndef SWP_MAP_VH
`define SWP_MAP_VH

// Register byte offsets.
`define SWP_CTRL_OFS 8'h00
`define SWP_STATUS_OFS 8'h04
`define SWP_WCNT_OFS 8'h08
`define SWP_RCNT_OFS 8'h0C
`define SWP_WADDR_OFS 8'h10
`define SWP_RADDR_OFS 8'h14
`define SWP_PEEK_SEL_OFS 8'h18
`define SWP_PEEK_DATA_OFS 8'h1C

// Control fields.
`define SWP_CTRL_MODE_LSB 0
`define SWP_CTRL_MODE_MSB 1
`define SWP_CTRL_HOLD_BIT 2
`define SWP_CTRL_RST 32'h00000003

// Width modes.
`define SWP_MODE_X8 2'h0
`define SWP_MODE_X9 2'h1
`define SWP_MODE_X18 2'h2
`define SWP_MODE_X36 2'h3

// Address widths per mode.
`define SWP_AW_X8 20
`define SWP_AW_X18 19
`define SWP_AW_X36 18

// Status fields.
`define SWP_STAT_OVF_BIT 0
`define SWP_STAT_EMPTY_BIT 1
`define SWP_STAT_FULL_BIT 2

// Buffering and local store.
`define SWP_FIFO_DEPTH 4
`define SWP_STORE_AW 4

// AXI responses.
`define SWP_RESP_OKAY 2'h0
`define SWP_RESP_SLVERR 2'h2

`endif

// ---- swp_capture.v ----
// Write-port and shared-address capture of a two-word-burst DDR SRAM, with an AXI4-Lite
// register slave, a four-entry write FIFO and a small local store that the writes land in.
// Assumes all pins are asynchronous to aclk and that the input clock pair is far slower
// than aclk (every half period spans several aclk cycles).
//
// How it works
// - Data words are taken at rising edges of both input clocks during a write.
// - Low write select at positive clock rise starts a write.
// - High write select leaves the write port idle and data ignored.
// - Nibble masks in x8 are taken with the data word they qualify.
// - First nibble mask covers bits 3..0, second covers bits 7..4.
// - A nibble with a high mask is not written and keeps its value.
// - Byte masks in wider modes are taken per word and gate byte lanes.
// - A byte lane with a high mask stays unchanged.
// - In x9 one byte mask gates all nine bits.
// - Read address at positive clock rise, write address at negative clock rise.
// - Address width is 20, 19 or 18 bits by mode.
// - Address is ignored at an edge whose port is deselected.
// - Low read select at positive rise starts a two-word read.
// - Every access starts at a positive clock rise.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "swp_map.vh"

////////////////////////////////////////////////////////////////////////////////

module swp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // Filling side.
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side.
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // Levels.
  output wire full,
  output wire empty
);
  localparam PW = $clog2(DEPTH);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] wp;
  reg [PW-1:0] rp;
  reg [PW:0] cnt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign full = (cnt == DEPTH);
  assign empty = (cnt == 0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp];
  always @(posedge aclk) begin
    if (!aresetn) begin
      wp <= {PW{1'b0}};
      rp <= {PW{1'b0}};
      cnt <= {(PW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= (wp == DEPTH - 1) ? {PW{1'b0}} : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == DEPTH - 1) ? {PW{1'b0}} : rp + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
  always @(posedge aclk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule // swp_fifo

////////////////////////////////////////////////////////////////////////////////

module swp_capture (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data.
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response.
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read.
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Memory pins.
  input wire k_clk,
  input wire k_clk_n,
  input wire write_port_select_n,
  input wire read_port_select_n,
  input wire [19:0] addr,
  input wire [35:0] data,
  input wire [1:0] nibble_write_mask_n,
  input wire [3:0] byte_write_mask_n
);
  localparam PIN_W = 2 + 2 + 20 + 36 + 2 + 4;
  localparam REC_W = 20 + 36 + 36 + 36 + 36;
  localparam ST_IDLE = 1'b0;
  localparam ST_WORD1 = 1'b1;

  // Lane enables for one word from its sampled masks.
  function [35:0] lane_en;
    input [1:0] mode;
    input [1:0] nib_n;
    input [3:0] byt_n;
    begin
      case (mode)
        `SWP_MODE_X8: lane_en = {28'h0000000, {4{~nib_n[1]}}, {4{~nib_n[0]}}};
        `SWP_MODE_X9: lane_en = {27'h0000000, {9{~byt_n[0]}}};
        `SWP_MODE_X18: lane_en = {18'h00000, {9{~byt_n[1]}}, {9{~byt_n[0]}}};
        default: lane_en = {{9{~byt_n[3]}}, {9{~byt_n[2]}}, {9{~byt_n[1]}}, {9{~byt_n[0]}}};
      endcase
    end
  endfunction

  // Address cut to the width of the mode.
  function [19:0] addr_cut;
    input [1:0] mode;
    input [19:0] a;
    begin
      case (mode)
        `SWP_MODE_X18: addr_cut = {{(20-`SWP_AW_X18){1'b0}}, a[`SWP_AW_X18-1:0]};
        `SWP_MODE_X36: addr_cut = {{(20-`SWP_AW_X36){1'b0}}, a[`SWP_AW_X36-1:0]};
        default: addr_cut = a[`SWP_AW_X8-1:0];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a clock change counts once the second and third stage agree.

  wire [PIN_W-1:0] pins = {k_clk, k_clk_n, write_port_select_n, read_port_select_n, addr,
                           data, nibble_write_mask_n, byte_write_mask_n};
  reg [PIN_W-1:0] sync1;
  reg [PIN_W-1:0] sync2;
  reg [PIN_W-1:0] sync3;
  reg k_stable;
  reg kn_stable;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= {PIN_W{1'b0}};
      sync2 <= {PIN_W{1'b0}};
      sync3 <= {PIN_W{1'b0}};
      k_stable <= 1'b0;
      kn_stable <= 1'b0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2[PIN_W-1] == sync3[PIN_W-1]) begin
        k_stable <= sync3[PIN_W-1];
      end
      if (sync2[PIN_W-2] == sync3[PIN_W-2]) begin
        kn_stable <= sync3[PIN_W-2];
      end
    end
  end
  wire k_rise = (sync2[PIN_W-1] == sync3[PIN_W-1]) && sync3[PIN_W-1] && !k_stable;
  wire kn_rise = (sync2[PIN_W-2] == sync3[PIN_W-2]) && sync3[PIN_W-2] && !kn_stable;
  wire s_wsel_n = sync3[PIN_W-3];
  wire s_rsel_n = sync3[PIN_W-4];
  wire [19:0] s_addr = sync3[61:42];
  wire [35:0] s_data = sync3[41:6];
  wire [1:0] s_nib_n = sync3[5:4];
  wire [3:0] s_byt_n = sync3[3:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Registers seen by software.

  reg [1:0] mode;
  reg hold;
  reg overflow;
  reg [31:0] wr_count;
  reg [31:0] rd_count;
  reg [19:0] last_waddr;
  reg [19:0] last_raddr;
  reg [4:0] peek_sel;

  ////////////////////////////////////////////////////////////////////////////////
  // Capture of bursts.

  reg wstate;
  reg [35:0] word0;
  reg [35:0] en0;
  reg push_valid;
  reg [REC_W-1:0] push_rec;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [REC_W-1:0] fifo_out_data;
  wire fifo_full;
  wire fifo_empty;
  wire drain = fifo_out_valid && !hold;
  wire ovf_set = push_valid && !fifo_in_ready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= ST_IDLE;
      word0 <= 36'h000000000;
      en0 <= 36'h000000000;
      push_valid <= 1'b0;
      push_rec <= {REC_W{1'b0}};
      rd_count <= 32'h00000000;
      last_raddr <= 20'h00000;
    end else begin
      push_valid <= 1'b0;
      if (k_rise) begin
        if (!s_wsel_n) begin
          word0 <= s_data;
          en0 <= lane_en(mode, s_nib_n, s_byt_n);
          wstate <= ST_WORD1;
        end else begin
          wstate <= ST_IDLE;
        end
        if (!s_rsel_n) begin
          last_raddr <= addr_cut(mode, s_addr);
          rd_count <= rd_count + 32'h00000001;
        end
      end else if (kn_rise && wstate == ST_WORD1) begin
        push_rec <= {addr_cut(mode, s_addr), word0, en0, s_data,
                     lane_en(mode, s_nib_n, s_byt_n)};
        push_valid <= 1'b1;
        wstate <= ST_IDLE;
      end
    end
  end

  swp_fifo #(
    .WIDTH(REC_W),
    .DEPTH(`SWP_FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_rec),
    .out_valid(fifo_out_valid),
    .out_ready(!hold),
    .out_data(fifo_out_data),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Local store: one array per burst word.

  reg [35:0] store0 [0:(1<<`SWP_STORE_AW)-1];
  reg [35:0] store1 [0:(1<<`SWP_STORE_AW)-1];
  wire [`SWP_STORE_AW-1:0] d_idx = fifo_out_data[REC_W-20 +: `SWP_STORE_AW];
  wire [35:0] d_w0 = fifo_out_data[108 +: 36];
  wire [35:0] d_e0 = fifo_out_data[72 +: 36];
  wire [35:0] d_w1 = fifo_out_data[36 +: 36];
  wire [35:0] d_e1 = fifo_out_data[0 +: 36];
  always @(posedge aclk) begin
    if (drain) begin
      store0[d_idx] <= (d_w0 & d_e0) | (store0[d_idx] & ~d_e0);
      store1[d_idx] <= (d_w1 & d_e1) | (store1[d_idx] & ~d_e1);
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_count <= 32'h00000000;
      last_waddr <= 20'h00000;
    end else if (drain) begin
      wr_count <= wr_count + 32'h00000001;
      last_waddr <= fifo_out_data[REC_W-1 -: 20];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  reg aw_have;
  reg w_have;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire w_ctrl = do_write && aw_addr == `SWP_CTRL_OFS;
  wire w_stat = do_write && aw_addr == `SWP_STATUS_OFS;
  wire w_sel = do_write && aw_addr == `SWP_PEEK_SEL_OFS;
  wire w_ok = w_ctrl || w_stat || w_sel;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SWP_RESP_OKAY;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      mode <= `SWP_MODE_X36;
      hold <= 1'b0;
      peek_sel <= 5'h00;
      overflow <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= {s_axi_awaddr[7:2], 2'h0};
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_ok ? `SWP_RESP_OKAY : `SWP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (w_ctrl && w_strb[0]) begin
        mode <= w_data[`SWP_CTRL_MODE_MSB:`SWP_CTRL_MODE_LSB];
        hold <= w_data[`SWP_CTRL_HOLD_BIT];
      end
      if (w_sel && w_strb[0]) begin
        peek_sel <= w_data[4:0];
      end
      // Overflow is sticky; a new overflow wins over a write-one clear.
      if (ovf_set) begin
        overflow <= 1'b1;
      end else if (w_stat && w_strb[0] && w_data[`SWP_STAT_OVF_BIT]) begin
        overflow <= 1'b0;
      end
    end
  end

  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'h0})
      `SWP_CTRL_OFS: rd_mux = {29'h00000000, hold, mode};
      `SWP_STATUS_OFS: rd_mux = {29'h00000000, fifo_full, fifo_empty, overflow};
      `SWP_WCNT_OFS: rd_mux = wr_count;
      `SWP_RCNT_OFS: rd_mux = rd_count;
      `SWP_WADDR_OFS: rd_mux = {12'h000, last_waddr};
      `SWP_RADDR_OFS: rd_mux = {12'h000, last_raddr};
      `SWP_PEEK_SEL_OFS: rd_mux = {27'h0000000, peek_sel};
      `SWP_PEEK_DATA_OFS: rd_mux = peek_sel[4] ? store1[peek_sel[3:0]][31:0]
                                               : store0[peek_sel[3:0]][31:0];
      default: begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SWP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `SWP_RESP_OKAY : `SWP_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // swp_capture

`default_nettype wire

// ---- swp_capture_props.sv ----
// Checker for the register slave of the write-port capture block.
// Assumes it is bound to swp_capture and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "swp_map.vh"

////////////////////////////////////////////////////////////////////////////////

module swp_capture_props (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels.
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence r_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence r_done;
    s_axi_rvalid && s_axi_rready;
  endsequence

  // The pair is latched at the take edge and answered one edge later.
  b_follows_w_a: assert property (w_taken |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after request");
  b_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  b_release_a: assert property (b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed after response");
  w_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  r_follows_ar_a: assert property (r_taken |=> s_axi_rvalid)
    else $error("read data not one cycle after request");
  r_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  r_release_a: assert property (r_done |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed after data");
  ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  err_data_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `SWP_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
endmodule // swp_capture_props

bind swp_capture swp_capture_props u_swp_capture_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

`default_nettype wire

// ---- swp_ctl_model.sv ----
// Model of the memory controller that drives the SRAM input pins.
// Assumes the caller waits for each cycle task to return before the next.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module swp_ctl_model (
  // Input clock pair.
  output logic k_clk,
  output logic k_clk_n,
  // Port selects.
  output logic write_port_select_n,
  output logic read_port_select_n,
  // Address, data and masks.
  output logic [19:0] addr,
  output logic [35:0] data,
  output logic [1:0] nibble_write_mask_n,
  output logic [3:0] byte_write_mask_n
);
  initial begin
    k_clk = 1'b0;
    k_clk_n = 1'b1;
    write_port_select_n = 1'b1;
    read_port_select_n = 1'b1;
    addr = 20'h0;
    data = 36'h0;
    nibble_write_mask_n = 2'h3;
    byte_write_mask_n = 4'hF;
  end

  // One clock period; the pair stands still between calls, released lines flip.
  task automatic cycle(input logic ws_n, rs_n, input logic [19:0] ra, wa,
                       input logic [35:0] w0, w1, input logic [3:0] m0, m1);
    #7;
    write_port_select_n = ws_n;
    read_port_select_n = rs_n;
    addr = ra;
    data = w0;
    nibble_write_mask_n = m0[1:0];
    byte_write_mask_n = m0;
    #40;
    k_clk = 1'b1;
    k_clk_n = 1'b0;
    #40;
    addr = wa;
    data = w1;
    nibble_write_mask_n = m1[1:0];
    byte_write_mask_n = m1;
    #40;
    k_clk = 1'b0;
    k_clk_n = 1'b1;
    #40;
    write_port_select_n = 1'b1;
    read_port_select_n = 1'b1;
    addr = ~wa;
    data = ~w1;
    nibble_write_mask_n = ~m1[1:0];
    byte_write_mask_n = ~m1;
    #160;
  endtask
endmodule // swp_ctl_model

`default_nettype wire

// ---- swp_capture_tb.sv ----
// Self-checking bench of the write-port capture block with a reference model.
// Assumes swp_map.vh and the controller model are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "swp_map.vh"

////////////////////////////////////////////////////////////////////////////////

module swp_capture_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  wire k_clk, k_clk_n, write_port_select_n, read_port_select_n;
  wire [19:0] addr;
  wire [35:0] data;
  wire [1:0] nibble_write_mask_n;
  wire [3:0] byte_write_mask_n;
  int err_count = 0, comparisons = 0, cyc = 0, wcnt = 0, rcnt = 0, md;
  logic [35:0] st0 [16], st1 [16];
  logic [19:0] a;

  swp_capture u_swp_capture (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .k_clk, .k_clk_n, .write_port_select_n, .read_port_select_n,
    .addr, .data, .nibble_write_mask_n, .byte_write_mask_n);
  swp_ctl_model u_swp_ctl_model (.k_clk, .k_clk_n, .write_port_select_n, .read_port_select_n,
    .addr, .data, .nibble_write_mask_n, .byte_write_mask_n);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  task automatic close_out();
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task automatic axw(input logic [7:0] ad, input logic [31:0] dd);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] ad);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    axr(ad);
    chk(d, e);
    chk({30'h0, r}, {30'h0, `SWP_RESP_OKAY});
  endtask

  // Lanes whose mask is low take the new value; the rest keep the old one.
  function automatic logic [35:0] mrg(input logic [35:0] o, n, input logic [3:0] m);
    mrg = o;
    if (md == 0) begin
      if (!m[0]) mrg[3:0] = n[3:0];
      if (!m[1]) mrg[7:4] = n[7:4];
    end else if (md == 1) begin
      if (!m[0]) mrg[8:0] = n[8:0];
    end else for (int i = 0; i < 2 * md - 2; i++) if (!m[i]) mrg[i * 9 +: 9] = n[i * 9 +: 9];
  endfunction

  function automatic logic [31:0] wm();
    return md == 0 ? 32'hFF : md == 1 ? 32'h1FF : md == 2 ? 32'h3FFFF : 32'hFFFFFFFF;
  endfunction

  function automatic logic [31:0] cm();
    return md < 2 ? 32'hFFFFF : md == 2 ? 32'h7FFFF : 32'h3FFFF;
  endfunction

  task automatic wr(input logic [3:0] m0, m1);
    logic [35:0] w0, w1;
    w0 = {4'($urandom), $urandom};
    w1 = {4'($urandom), $urandom};
    u_swp_ctl_model.cycle(1'b0, 1'b1, ~a, a, w0, w1, m0, m1);
    st0[a[3:0]] = mrg(st0[a[3:0]], w0, m0);
    st1[a[3:0]] = mrg(st1[a[3:0]], w1, m1);
    wcnt++;
  endtask

  task automatic pk(input logic [4:0] sel, input logic [35:0] e);
    axw(`SWP_PEEK_SEL_OFS, {27'h0, sel});
    axr(`SWP_PEEK_DATA_OFS);
    chk(d & wm(), e[31:0] & wm());
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    void'($urandom(89));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`SWP_CTRL_OFS, 32'h3);
    rdc(`SWP_STATUS_OFS, 32'h2);
    rdc(`SWP_WCNT_OFS, 32'h0);
    rdc(`SWP_RCNT_OFS, 32'h0);
    for (md = 0; md < 4; md++) begin
      axw(`SWP_CTRL_OFS, 32'(md));
      a = 20'($urandom);
      wr(4'h0, 4'h0);
      wr(4'($urandom), 4'($urandom));
      u_swp_ctl_model.cycle(1'b1, 1'b1, a, ~a, 36'h0, 36'hFFFFFFFFF, 4'h0, 4'h0);
      rdc(`SWP_WCNT_OFS, 32'(wcnt));
      pk({1'b0, a[3:0]}, st0[a[3:0]]);
      pk({1'b1, a[3:0]}, st1[a[3:0]]);
      u_swp_ctl_model.cycle(1'b1, 1'b0, ~a, a ^ 20'h5, 36'h0, 36'h0, 4'hF, 4'hF);
      rcnt++;
      rdc(`SWP_RCNT_OFS, 32'(rcnt));
      rdc(`SWP_RADDR_OFS, 32'(~a) & cm());
      rdc(`SWP_WADDR_OFS, 32'(a) & cm());
    end
    md = 3;
    axw(`SWP_CTRL_OFS, 32'h7);
    repeat (5) u_swp_ctl_model.cycle(1'b0, 1'b1, 20'h0, 20'h1, 36'h0, 36'h0, 4'h0, 4'h0);
    rdc(`SWP_STATUS_OFS, 32'h5);
    rdc(`SWP_WCNT_OFS, 32'(wcnt));
    axw(`SWP_CTRL_OFS, 32'h3);
    repeat (8) @(posedge aclk);
    wcnt += 4;
    rdc(`SWP_WCNT_OFS, 32'(wcnt));
    rdc(`SWP_STATUS_OFS, 32'h3);
    axw(`SWP_STATUS_OFS, 32'h1);
    rdc(`SWP_STATUS_OFS, 32'h2);
    axw(`SWP_WCNT_OFS, 32'h0);
    chk({30'h0, r}, {30'h0, `SWP_RESP_SLVERR});
    axr(8'h40);
    chk({30'h0, r}, {30'h0, `SWP_RESP_SLVERR});
    chk(d, 32'h0);
    close_out();
  end
endmodule // swp_capture_tb

`default_nettype wire
